// *** design/cmpc_sync.sv ***
// two-flop synchronizer for a level from outside the clock domain
`timescale 1ns/1ps
module cmpc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = clkEn ? asyncIn : meta_reg;
        sync_next = clkEn ? meta_reg : sync_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign syncOut = sync_reg;
endmodule

// *** design/cmpc_top.sv ***
// comparator control: registers, input select, edge flag, sleep gating
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module cmpc_top
    import cmpc_pkg::*;
#(
    parameter int STARTUP_VREF_CYC = CMPC_STARTUP_VREF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CMPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sleep state from the power controller, same clock domain
    input wire logic [1:0] sleepMode,
    // analog core
    input wire logic cmpRaw,
    output logic analogEnable,
    output logic [1:0] hysteresisSelect,
    output logic positivePinZero,
    output logic positivePinOne,
    output logic negativePinZero,
    output logic negativePinOne,
    output logic negativeVref,
    // outputs to system
    output logic cmpResultValid,
    output logic eventOut,
    output logic padOut,
    output logic padOutEn,
    output logic irqReq
);
    logic [7:0] mainControl_reg;
    logic [7:0] mainControl_next;
    logic [7:0] inputSelect_reg;
    logic [7:0] inputSelect_next;
    logic irqEnable_reg;
    logic irqEnable_next;
    logic flag_reg;
    logic flag_next;
    logic state_reg;
    logic state_next;
    logic [CMPC_STARTUP_W-1:0] startup_reg;
    logic [CMPC_STARTUP_W-1:0] startup_next;
    logic startupDone_reg;
    logic startupDone_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    logic enableBit;
    logic keepRunningInStandby;
    logic padOutputEnable;
    logic invertBit;
    cmpc_edge_t edgeSelect;
    cmpc_sleep_t sleepState;
    logic [1:0] positiveInputSelect;
    logic [1:0] negativeInputSelect;
    logic cmpActive;
    logic inputsValid;
    logic resultInv;
    logic resultSync;
    logic rising;
    logic falling;
    logic edgeHit;
    logic access;
    logic wrEn;
    logic mapped;
    logic [2:0] regIdx;
    logic lowLane;
    logic [CMPC_STARTUP_W-1:0] startupLoad;

    assign enableBit = mainControl_reg[CMPC_ENABLE_BIT];
    assign keepRunningInStandby = mainControl_reg[CMPC_STANDBY_BIT];
    assign padOutputEnable = mainControl_reg[CMPC_PAD_EN_BIT];
    assign edgeSelect = cmpc_edge_t'(mainControl_reg[CMPC_EDGE_LSB +: 2]);
    assign invertBit = inputSelect_reg[CMPC_INVERT_BIT];
    assign positiveInputSelect = inputSelect_reg[CMPC_POS_LSB +: 2];
    assign negativeInputSelect = inputSelect_reg[CMPC_NEG_LSB +: 2];
    assign sleepState = cmpc_sleep_t'(sleepMode);

    always_comb begin
        unique case (sleepState)
            CMPC_SLEEP_ACTIVE: cmpActive = enableBit;
            CMPC_SLEEP_IDLE: cmpActive = enableBit;
            CMPC_SLEEP_STANDBY: cmpActive = enableBit & keepRunningInStandby;
            CMPC_SLEEP_POWERDOWN: cmpActive = 1'b0;
        endcase
    end

    assign positivePinZero = cmpActive & (positiveInputSelect == CMPC_POS_PIN_ZERO);
    assign positivePinOne = cmpActive & (positiveInputSelect == CMPC_POS_PIN_ONE);
    assign negativePinZero = cmpActive & (negativeInputSelect == CMPC_NEG_PIN_ZERO);
    assign negativePinOne = cmpActive & (negativeInputSelect == CMPC_NEG_PIN_ONE);
    assign negativeVref = cmpActive & (negativeInputSelect == CMPC_NEG_VREF);
    assign inputsValid = (positivePinZero | positivePinOne)
        & (negativePinZero | negativePinOne | negativeVref);

    // hysteresis passed straight to the analog core
    assign hysteresisSelect = mainControl_reg[CMPC_HYST_LSB +: 2];
    assign analogEnable = cmpActive;

    // raw result is the core's pos-above-neg output
    assign resultInv = cmpRaw ^ invertBit;

    // event path bypasses all clocks so it works with the clock stopped
    // no event input exists on this block
    assign eventOut = cmpActive & resultInv;

    // pad released in power-down through cmpActive
    assign padOutEn = cmpActive & padOutputEnable;
    assign padOut = padOutEn & resultInv;

    cmpc_sync #(
        .WIDTH(1)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .asyncIn(resultInv),
        .syncOut(resultSync)
    );

    // start-up window, longer when the reference is the negative input
    always_comb begin
        // decoded field, not negativeVref: that one is gated off while the counter loads
        startupLoad = CMPC_STARTUP_W'(CMPC_STARTUP_CORE_CYC);
        if (negativeInputSelect == CMPC_NEG_VREF) begin
            startupLoad = CMPC_STARTUP_W'(STARTUP_VREF_CYC);
        end
        startup_next = startup_reg;
        startupDone_next = startupDone_reg;
        if (clkEn) begin
            if (!cmpActive) begin
                startup_next = startupLoad;
                startupDone_next = 1'b0;
            end else if (startup_reg > CMPC_STARTUP_W'(1)) begin
                startup_next = startup_reg - CMPC_STARTUP_W'(1);
            end else begin
                startup_next = '0;
                startupDone_next = 1'b1;
            end
        end
    end
    assign cmpResultValid = startupDone_reg & inputsValid;

    // third flop after the synchronizer gives the three-cycle state
    // state_reg is the previous sample for edge compare
    assign rising = resultSync & ~state_reg;
    assign falling = ~resultSync & state_reg;

    always_comb begin
        unique case (edgeSelect)
            CMPC_EDGE_ANY: edgeHit = rising | falling;
            CMPC_EDGE_RSVD: edgeHit = 1'b0;
            CMPC_EDGE_FALL: edgeHit = falling;
            CMPC_EDGE_RISE: edgeHit = rising;
        endcase
    end

    // apb decode; each byte register sits in the low lane of its word
    assign access = psel & penable & clkEn;
    assign wrEn = access & pwrite;
    assign regIdx = paddr[4:2];
    assign lowLane = pstrb[0];
    always_comb begin
        unique case (regIdx)
            CMPC_IDX_MAIN_CONTROL: mapped = (paddr[1:0] == 2'h0);
            CMPC_IDX_INPUT_SELECT: mapped = (paddr[1:0] == 2'h0);
            CMPC_IDX_IRQ_ENABLE: mapped = (paddr[1:0] == 2'h0);
            CMPC_IDX_STATUS: mapped = (paddr[1:0] == 2'h0);
            default: mapped = 1'b0;
        endcase
    end
    // pready waits on clkEn so no transfer completes while state is frozen
    assign pready = clkEn;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        mainControl_next = mainControl_reg;
        inputSelect_next = inputSelect_reg;
        irqEnable_next = irqEnable_reg;
        flag_next = flag_reg;
        state_next = state_reg;
        prdata_next = prdata_reg;
        if (clkEn) begin
            // state bit only moves while the core runs on a live clock
            if (cmpActive) begin
                state_next = resultSync;
            end
            if (wrEn && mapped && lowLane) begin
                unique case (regIdx)
                    CMPC_IDX_MAIN_CONTROL: mainControl_next = pwdata[7:0];
                    CMPC_IDX_INPUT_SELECT:
                        inputSelect_next = pwdata[7:0] & CMPC_INPUT_SELECT_MASK;
                    CMPC_IDX_IRQ_ENABLE: irqEnable_next = pwdata[CMPC_IRQ_BIT];
                    CMPC_IDX_STATUS: begin
                        if (pwdata[CMPC_IRQ_BIT]) begin
                            flag_next = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // flag set regardless of enable; set beats a same-cycle clear
            if (cmpActive && startupDone_reg && inputsValid && edgeHit) begin
                flag_next = 1'b1;
            end
            // read data latched in the setup cycle, so the access phase shows a flop
            prdata_next = '0;
            if (psel && !penable && !pwrite) begin
                unique case (regIdx)
                    CMPC_IDX_MAIN_CONTROL: prdata_next[7:0] = mainControl_reg;
                    CMPC_IDX_INPUT_SELECT: prdata_next[7:0] = inputSelect_reg;
                    CMPC_IDX_IRQ_ENABLE: prdata_next[CMPC_IRQ_BIT] = irqEnable_reg;
                    CMPC_IDX_STATUS: begin
                        prdata_next[CMPC_STATE_BIT] = state_reg;
                        prdata_next[CMPC_IRQ_BIT] = flag_reg;
                    end
                    default: prdata_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainControl_reg <= CMPC_MAIN_CONTROL_RST;
            inputSelect_reg <= CMPC_INPUT_SELECT_RST;
            irqEnable_reg <= CMPC_IRQ_ENABLE_RST[CMPC_IRQ_BIT];
            flag_reg <= CMPC_STATUS_RST[CMPC_IRQ_BIT];
            state_reg <= CMPC_STATUS_RST[CMPC_STATE_BIT];
            startup_reg <= '0;
            startupDone_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            mainControl_reg <= mainControl_next;
            inputSelect_reg <= inputSelect_next;
            irqEnable_reg <= irqEnable_next;
            flag_reg <= flag_next;
            state_reg <= state_next;
            startup_reg <= startup_next;
            startupDone_reg <= startupDone_next;
            prdata_reg <= prdata_next;
        end
    end

    // limitation: a read whose setup cycle falls while clkEn is low returns stale data
    assign prdata = prdata_reg;

    // request follows enable and flag until the flag clears
    assign irqReq = irqEnable_reg & flag_reg;
endmodule

// *** pkg/cmpc_pkg.sv ***
// constants and types shared by the comparator control block
package cmpc_pkg;
    // register indices; byte address is four times the index
    localparam logic [2:0] CMPC_IDX_MAIN_CONTROL = 3'h0;
    localparam logic [2:0] CMPC_IDX_INPUT_SELECT = 3'h2;
    localparam logic [2:0] CMPC_IDX_IRQ_ENABLE = 3'h6;
    localparam logic [2:0] CMPC_IDX_STATUS = 3'h7;
    localparam int CMPC_ADDR_W = 5;

    // main control fields
    localparam int CMPC_ENABLE_BIT = 0;
    localparam int CMPC_HYST_LSB = 1;
    localparam int CMPC_EDGE_LSB = 4;
    localparam int CMPC_PAD_EN_BIT = 6;
    localparam int CMPC_STANDBY_BIT = 7;
    // input select fields
    localparam int CMPC_NEG_LSB = 0;
    localparam int CMPC_POS_LSB = 3;
    localparam int CMPC_INVERT_BIT = 7;
    localparam logic [7:0] CMPC_INPUT_SELECT_MASK = 8'h9b;
    // irq enable and status fields
    localparam int CMPC_IRQ_BIT = 0;
    localparam int CMPC_STATE_BIT = 4;

    // values after reset
    localparam logic [7:0] CMPC_MAIN_CONTROL_RST = 8'h00;
    localparam logic [7:0] CMPC_INPUT_SELECT_RST = 8'h00;
    localparam logic [7:0] CMPC_IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] CMPC_STATUS_RST = 8'h00;

    // field encodings
    localparam logic [1:0] CMPC_POS_PIN_ZERO = 2'h0;
    localparam logic [1:0] CMPC_POS_PIN_ONE = 2'h1;
    localparam logic [1:0] CMPC_NEG_PIN_ZERO = 2'h0;
    localparam logic [1:0] CMPC_NEG_PIN_ONE = 2'h1;
    localparam logic [1:0] CMPC_NEG_VREF = 2'h2;

    typedef enum logic [1:0] {
        CMPC_EDGE_ANY = 2'b00,
        CMPC_EDGE_RSVD = 2'b01,
        CMPC_EDGE_FALL = 2'b10,
        CMPC_EDGE_RISE = 2'b11
    } cmpc_edge_t;

    typedef enum logic [1:0] {
        CMPC_SLEEP_ACTIVE = 2'b00,
        CMPC_SLEEP_IDLE = 2'b01,
        CMPC_SLEEP_STANDBY = 2'b10,
        CMPC_SLEEP_POWERDOWN = 2'b11
    } cmpc_sleep_t;

    // start-up times and cycle counts at 100 MHz
    localparam int CMPC_CLK_MHZ = 100;
    localparam int CMPC_STARTUP_CORE_NS = 2500;
    localparam int CMPC_STARTUP_VREF_NS = 60000;
    localparam int CMPC_STARTUP_CORE_CYC = (CMPC_STARTUP_CORE_NS * CMPC_CLK_MHZ + 999) / 1000;
    localparam int CMPC_STARTUP_VREF_CYC = (CMPC_STARTUP_VREF_NS * CMPC_CLK_MHZ + 999) / 1000;
    localparam int CMPC_STARTUP_W = 16;
endpackage

// *** sim/cmpc_chk_sva.sv ***
// port assertions for the comparator control block
`timescale 1ns/1ps
module cmpc_chk
    import cmpc_pkg::*;
#(
    parameter int STARTUP_VREF_CYC = CMPC_STARTUP_VREF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CMPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [1:0] sleepMode,
    input wire logic analogEnable,
    input wire logic [1:0] hysteresisSelect,
    input wire logic positivePinZero,
    input wire logic positivePinOne,
    input wire logic negativePinZero,
    input wire logic negativePinOne,
    input wire logic negativeVref,
    input wire logic cmpResultValid,
    input wire logic eventOut,
    input wire logic padOut,
    input wire logic padOutEn,
    input wire logic irqReq
);
    int onCnt_reg;
    int onCnt_next;
    int lim;
    logic wr;
    logic wrIrq;
    logic [2:0] idx;
    assign idx = paddr[4:2];
    assign wr = psel && penable && pwrite && pready && pstrb[0] && paddr[1:0] == 2'h0;
    assign wrIrq = wr && (idx == CMPC_IDX_STATUS || idx == CMPC_IDX_IRQ_ENABLE);
    assign lim = negativeVref ? STARTUP_VREF_CYC : CMPC_STARTUP_CORE_CYC;
    // saturating, so a long enable never wraps the count
    always_comb begin
        onCnt_next = !analogEnable ? 0 : onCnt_reg + int'(clkEn && onCnt_reg < 100000);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            onCnt_reg <= 0;
        else
            onCnt_reg <= onCnt_next;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    hyst_follow_a: assert property (wr && idx == CMPC_IDX_MAIN_CONTROL
        |=> hysteresisSelect == $past(pwdata[2:1])) else $error("hysteresis not from register");
    mux_onehot_a: assert property ($onehot0({positivePinZero, positivePinOne})
        && $onehot0({negativePinZero, negativePinOne, negativeVref})) else $error("select clash");
    mux_idle_a: assert property (!analogEnable |-> !(positivePinZero || positivePinOne
        || negativePinZero || negativePinOne || negativeVref)) else $error("select while off");
    start_wait_a: assert property (cmpResultValid |-> onCnt_reg >= lim - 2)
        else $error("valid before start-up");
    event_gate_a: assert property (!analogEnable |-> !eventOut && !padOutEn)
        else $error("output while off");
    pad_match_a: assert property (padOut == (padOutEn && eventOut))
        else $error("pad differs from event");
    power_down_a: assert property (sleepMode == CMPC_SLEEP_POWERDOWN
        |-> !analogEnable && !padOut) else $error("active in power-down");
    irq_hold_a: assert property ($fell(irqReq) |-> $past(wrIrq))
        else $error("irq dropped without write");
    irq_mask_a: assert property (wr && idx == CMPC_IDX_IRQ_ENABLE && !pwdata[0]
        |=> !irqReq) else $error("irq while disabled");
    cover property ($rose(irqReq));
    cover property ($rose(cmpResultValid) && negativeVref);
    cover property (padOutEn && sleepMode == CMPC_SLEEP_STANDBY);
endmodule
bind cmpc_top cmpc_chk #(.STARTUP_VREF_CYC(STARTUP_VREF_CYC)) cmpc_chk_i (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .sleepMode(sleepMode), .analogEnable(analogEnable), .hysteresisSelect(hysteresisSelect),
    .positivePinZero(positivePinZero), .positivePinOne(positivePinOne),
    .negativePinZero(negativePinZero), .negativePinOne(negativePinOne),
    .negativeVref(negativeVref), .cmpResultValid(cmpResultValid), .eventOut(eventOut),
    .padOut(padOut), .padOutEn(padOutEn), .irqReq(irqReq)
);

// *** sim/cmpc_core_model.sv ***
// behavioural analog core: pin voltages in, raw comparison out
`timescale 1ns/1ps
module cmpc_core_model (
    input wire logic clk,
    input wire logic analogEnable,
    input wire logic positivePinZero,
    input wire logic positivePinOne,
    input wire logic negativePinZero,
    input wire logic negativePinOne,
    input wire logic negativeVref,
    input int vP0,
    input int vP1,
    input int vN0,
    input int vN1,
    input int vRef,
    output logic cmpRaw
);
    int vPos;
    int vNeg;
    logic legal;
    logic wander = 1'b0;
    // a core that is off or unconnected gives no stable level
    always @(posedge clk) wander <= ~wander;
    always_comb begin
        vPos = positivePinOne ? vP1 : vP0;
        vNeg = negativeVref ? vRef : (negativePinOne ? vN1 : vN0);
        legal = analogEnable && (positivePinZero || positivePinOne);
        legal = legal && (negativePinZero || negativePinOne || negativeVref);
    end
    assign cmpRaw = legal ? (vPos > vNeg) : wander;
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module testbench
    import cmpc_pkg::*;
;
    localparam int VREF_CYC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] sleepMode = 2'h0;
    int vP0 = 10;
    int vP1 = 40;
    int vN0 = 20;
    int vN1 = 20;
    int vRef = 25;
    int n_mismatch = 0;
    int checks = 0;
    logic [31:0] prdata;
    logic [1:0] hysteresisSelect;
    logic pready, pslverr, cmpRaw, analogEnable, cmpResultValid, eventOut, padOut;
    logic padOutEn, irqReq, positivePinZero, positivePinOne;
    logic negativePinZero, negativePinOne, negativeVref;
    always #5 clk = ~clk;
    cmpc_top #(.STARTUP_VREF_CYC(VREF_CYC)) cmpc_top_i (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleepMode(sleepMode), .cmpRaw(cmpRaw),
        .analogEnable(analogEnable), .hysteresisSelect(hysteresisSelect),
        .positivePinZero(positivePinZero), .positivePinOne(positivePinOne),
        .negativePinZero(negativePinZero), .negativePinOne(negativePinOne),
        .negativeVref(negativeVref), .cmpResultValid(cmpResultValid), .eventOut(eventOut),
        .padOut(padOut), .padOutEn(padOutEn), .irqReq(irqReq)
    );
    cmpc_core_model cmpc_core_model_i (
        .clk(clk), .analogEnable(analogEnable), .positivePinZero(positivePinZero),
        .positivePinOne(positivePinOne), .negativePinZero(negativePinZero),
        .negativePinOne(negativePinOne), .negativeVref(negativeVref), .vP0(vP0),
        .vP1(vP1), .vN0(vN0), .vN1(vN1), .vRef(vRef), .cmpRaw(cmpRaw)
    );
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            chk("pready", 32'(pready), 32'h1);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, {i, 2'b00}, d, r, e);
        @(negedge clk);
    endtask
    task automatic rdc(input string nm, input logic [2:0] i, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, {i, 2'b00}, 8'h00, r, e);
        chk(nm, r, {24'h0, exp});
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rdc("main", CMPC_IDX_MAIN_CONTROL, CMPC_MAIN_CONTROL_RST);
        rdc("mux", CMPC_IDX_INPUT_SELECT, CMPC_INPUT_SELECT_RST);
        rdc("irqen", CMPC_IDX_IRQ_ENABLE, CMPC_IRQ_ENABLE_RST);
        rdc("status", CMPC_IDX_STATUS, CMPC_STATUS_RST);
        apb(1'b1, 5'h04, 8'hff, r, e);
        chk("unmapped err", 32'(e), 32'h1);
        wr(CMPC_IDX_INPUT_SELECT, 8'hff);
        rdc("mux mask", CMPC_IDX_INPUT_SELECT, CMPC_INPUT_SELECT_MASK);
    endtask
    task automatic t_select();
        logic [4:0] exp;
        for (int p = 0; p < 4; p++) begin
            for (int n = 0; n < 4; n++) begin
                wr(CMPC_IDX_INPUT_SELECT, 8'(p * 8 + n));
                wr(CMPC_IDX_MAIN_CONTROL, 8'(n * 2 + 1));
                exp = {p == 0, p == 1, n == 0, n == 1, n == 2};
                chk("sel", 32'({positivePinZero, positivePinOne, negativePinZero,
                    negativePinOne, negativeVref}), 32'(exp));
                chk("hyst", 32'(hysteresisSelect), 32'(n));
                wr(CMPC_IDX_MAIN_CONTROL, 8'h00);
            end
        end
    endtask
    task automatic t_start(input logic [7:0] mux, input logic [7:0] ctl, input int lim);
        wr(CMPC_IDX_INPUT_SELECT, mux);
        wr(CMPC_IDX_MAIN_CONTROL, ctl);
        cyc(lim - 5);
        chk("early", 32'(cmpResultValid), 32'h0);
        cyc(10);
        chk("valid", 32'(cmpResultValid), 32'h1);
    endtask
    task automatic t_edge();
        logic hit;
        for (int m = 0; m < 4; m++) begin
            vP0 <= 10;
            t_start(8'h00, 8'(m * 16 + 1), CMPC_STARTUP_CORE_CYC);
            wr(CMPC_IDX_IRQ_ENABLE, 8'h01);
            for (int up = 1; up >= 0; up--) begin
                wr(CMPC_IDX_STATUS, 8'h01);
                vP0 <= up ? 30 : 10;
                hit = (m == 0) || (m == 3 && up == 1) || (m == 2 && up == 0);
                rdc("state lag", CMPC_IDX_STATUS, 8'((1 - up) * 16));
                rdc("flag", CMPC_IDX_STATUS, 8'(up * 16 + int'(hit)));
                wr(CMPC_IDX_STATUS, 8'h00);
                chk("irq", 32'(irqReq), 32'(hit));
                wr(CMPC_IDX_IRQ_ENABLE, 8'h00);
                chk("irq off", 32'(irqReq), 32'h0);
                wr(CMPC_IDX_IRQ_ENABLE, 8'h01);
            end
            wr(CMPC_IDX_MAIN_CONTROL, 8'h00);
        end
    endtask
    task automatic t_invert();
        for (int k = 0; k < 8; k++) begin
            vP0 <= k[2] ? 30 : 10;
            wr(CMPC_IDX_INPUT_SELECT, 8'(k[0] * 128));
            wr(CMPC_IDX_MAIN_CONTROL, 8'(k[1] * 64 + 1));
            chk("event", 32'(eventOut), 32'(k[2] ^ k[0]));
            chk("pad", 32'({padOutEn, padOut}), 32'({k[1], k[1] & (k[2] ^ k[0])}));
        end
    endtask
    task automatic t_sleep();
        vP0 <= 30;
        wr(CMPC_IDX_INPUT_SELECT, 8'h00);
        wr(CMPC_IDX_MAIN_CONTROL, 8'h41);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            sleepMode <= 2'(s);
            @(negedge clk);
            chk("sleep pad", 32'(padOut), 32'(s < 2));
        end
        wr(CMPC_IDX_MAIN_CONTROL, 8'hc1);
        // stopped peripheral clock: only the async paths may move
        @(posedge clk);
        sleepMode <= CMPC_SLEEP_STANDBY;
        clkEn <= 1'b0;
        @(negedge clk);
        chk("standby on", 32'({analogEnable, padOut}), 32'h3);
        vP0 <= 10;
        @(negedge clk);
        chk("standby live", 32'({eventOut, padOut}), 32'h0);
        @(posedge clk);
        sleepMode <= CMPC_SLEEP_ACTIVE;
        clkEn <= 1'b1;
        wr(CMPC_IDX_MAIN_CONTROL, 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_select();
        t_edge();
        t_start(8'(CMPC_NEG_VREF), 8'h01, VREF_CYC);
        wr(CMPC_IDX_MAIN_CONTROL, 8'h00);
        t_invert();
        t_sleep();
        close_out();
    end
endmodule
